// >>> tws_assertions.sv
// Port checker for the two-wire block
`timescale 1ns/1ps
module tws_chk(
  input wire CLK_I, RST_B_I, MASTER_SELECT_I, SW_DATA_OUT_I, SW_DATA_DRIVE_ENABLE_I,
  input wire SW_CLOCK_OUT_I, INTERFACE_RESET_BIT_I, SPI_ENABLE_I, INT_ENABLE_I,
  input wire GLOBAL_INTERRUPT_ENABLE_I, DATA_RD_I, DATA_WR_I, BYTE_DONE_FLAG_O, HALTED_O,
  input wire IRQ_O, TWOWIRE_DATA_PIN_O, TWOWIRE_DATA_PIN_OE_O, TWOWIRE_CLOCK_PIN_O,
  input wire TWOWIRE_CLOCK_PIN_OE_O,
  input wire [15:0] IRQ_VECTOR_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  // Master mode in effect, expected request
  wire mst = MASTER_SELECT_I & !SPI_ENABLE_I;
  wire irq_exp = BYTE_DONE_FLAG_O & INT_ENABLE_I & GLOBAL_INTERRUPT_ENABLE_I;
  // Flag, interrupt and halt
  a_irq_gate: assert property (IRQ_O == irq_exp)
    else $error("irq gate");
  a_vector_fixed: assert property (IRQ_VECTOR_O == 16'h003B)
    else $error("vector");
  a_access_clr: assert property ((DATA_RD_I | DATA_WR_I) && BYTE_DONE_FLAG_O |=> !BYTE_DONE_FLAG_O)
    else $error("flag kept");
  a_stretch_low: assert property (BYTE_DONE_FLAG_O && !MASTER_SELECT_I && !SPI_ENABLE_I && !INTERFACE_RESET_BIT_I |=> TWOWIRE_CLOCK_PIN_OE_O && !TWOWIRE_CLOCK_PIN_O)
    else $error("no stretch");
  a_ifrst_idle: assert property (INTERFACE_RESET_BIT_I && !MASTER_SELECT_I |=> !BYTE_DONE_FLAG_O && !HALTED_O)
    else $error("reset bit");
  // Master and disabled pins
  a_clk_follow: assert property (mst |=> TWOWIRE_CLOCK_PIN_OE_O && TWOWIRE_CLOCK_PIN_O == $past(SW_CLOCK_OUT_I))
    else $error("clock pin");
  a_data_drive: assert property (mst && SW_DATA_DRIVE_ENABLE_I |=> TWOWIRE_DATA_PIN_OE_O && TWOWIRE_DATA_PIN_O == $past(SW_DATA_OUT_I))
    else $error("data pin");
  a_data_free: assert property (mst && !SW_DATA_DRIVE_ENABLE_I |=> !TWOWIRE_DATA_PIN_OE_O)
    else $error("data driven");
  a_pins_off: assert property (SPI_ENABLE_I |=> !TWOWIRE_CLOCK_PIN_OE_O && !TWOWIRE_DATA_PIN_OE_O)
    else $error("pins held");
endmodule
bind tws_top tws_chk u_chk(.*);

// >>> tws_ext_master.sv
// External bus master model, lines pulled up when released
`timescale 1ns/1ps
module tws_ext_master(
  input wire scl_i,
  input wire sda_i,
  output reg scl_o,
  output reg sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Release clock, wait out stretching, hold high
  task rise;
    integer n;
    begin
      scl_o = 1'b1;
      for (n = 0; n < 4000 && !scl_i; n = n + 1) #25;
      #100;
    end
  endtask
  // Data bit set mid low phase, sampled before the fall
  task xfer(input [8:0] tx, output [8:0] rx);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        scl_o = 1'b0;
        #50;
        sda_o = tx[i];
        #50;
        rise;
        rx[i] = sda_i;
      end
      scl_o = 1'b0;
      #100;
    end
  endtask
  // Frame start and stop
  task start_c;
    begin
      #100;
      sda_o = 1'b0;
      #100;
    end
  endtask
  task stop_c;
    begin
      scl_o = 1'b0;
      #50;
      sda_o = 1'b0;
      #50;
      rise;
      sda_o = 1'b1;
      #100;
    end
  endtask
endmodule

// >>> tws_filter.v
// Synchroniser and glitch filter for one two-wire line
`timescale 1ns/1ps
`include "tws_map.vh"
module tws_filter (
  input wire clk_i,
  input wire rst_b_i,
  input wire pin_i,
  output reg level_o
);
  reg sync1;
  reg sync2;
  reg [`TWS_FLT_W-1:0] cnt;

  // Two-stage synchroniser, then a stable-time counter
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      cnt <= {`TWS_FLT_W{1'b0}};
      level_o <= 1'b1;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
      if (sync2 == level_o) begin
        cnt <= {`TWS_FLT_W{1'b0}};
      end else if (cnt == `TWS_GLITCH_CYC) begin
        level_o <= sync2;
        cnt <= {`TWS_FLT_W{1'b0}};
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule

// >>> tws_map.vh
// Constants for the two-wire serial block
`ifndef TWS_MAP_VH
`define TWS_MAP_VH
`define TWS_OWN_ADDR_RST 7'h55
`define TWS_DATA_RST 8'h00
`define TWS_VECTOR 16'h003B
`define TWS_CLK_PERIOD_NS 25
`define TWS_GLITCH_NS 50
// Filter length: pulses under the glitch time are rejected (rounded up)
`define TWS_GLITCH_CYC ((`TWS_GLITCH_NS + `TWS_CLK_PERIOD_NS - 1) / `TWS_CLK_PERIOD_NS)
`define TWS_FLT_W 3
`endif

// >>> tws_tb.sv
// Testbench for the two-wire block
`timescale 1ns/1ps
module testbench;
  reg CLK_I = 1'b0, RST_B_I = 1'b0, MASTER_SELECT_I = 1'b0, SW_DATA_OUT_I = 1'b0;
  reg SW_DATA_DRIVE_ENABLE_I = 1'b0, SW_CLOCK_OUT_I = 1'b0, INTERFACE_RESET_BIT_I = 1'b0;
  reg SPI_ENABLE_I = 1'b0, INT_ENABLE_I = 1'b0, GLOBAL_INTERRUPT_ENABLE_I = 1'b0;
  reg DATA_WR_I = 1'b0, DATA_RD_I = 1'b0;
  reg [6:0] OWN_ADDRESS_I = 7'h55;
  reg [7:0] DATA_WDATA_I = 8'h00;
  wire [7:0] DATA_RDATA_O;
  wire [15:0] IRQ_VECTOR_O;
  wire SW_DATA_IN_O, BYTE_DONE_FLAG_O, SLAVE_DIRECTION_O, HALTED_O, IRQ_O, scl_m, sda_m;
  wire TWOWIRE_DATA_PIN_O, TWOWIRE_DATA_PIN_OE_O, TWOWIRE_CLOCK_PIN_O, TWOWIRE_CLOCK_PIN_OE_O;
  wire TWOWIRE_CLOCK_PIN_I, TWOWIRE_DATA_PIN_I;
  wire [3:0] pins = {TWOWIRE_CLOCK_PIN_OE_O, TWOWIRE_CLOCK_PIN_O, TWOWIRE_DATA_PIN_OE_O,
    TWOWIRE_DATA_PIN_O};
  integer err_count = 0;
  integer total_checks = 0;
  reg [8:0] rx;
  // Wired-and bus lines
  assign TWOWIRE_CLOCK_PIN_I = scl_m & (!TWOWIRE_CLOCK_PIN_OE_O | TWOWIRE_CLOCK_PIN_O);
  assign TWOWIRE_DATA_PIN_I = sda_m & (!TWOWIRE_DATA_PIN_OE_O | TWOWIRE_DATA_PIN_O);
  tws_top dut(.*);
  tws_ext_master mst(.scl_i(TWOWIRE_CLOCK_PIN_I), .sda_i(TWOWIRE_DATA_PIN_I), .scl_o(scl_m),
    .sda_o(sda_m));
  always #12.5 CLK_I = ~CLK_I;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
    end
  endtask
  task stop_test;
    begin
      if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Bounded wait for the flag, then compare
  task flag_wait(input e);
    integer n;
    begin
      for (n = 0; n < 80 && BYTE_DONE_FLAG_O !== 1'b1; n = n + 1) @(posedge CLK_I);
      #1;
      chk(BYTE_DONE_FLAG_O, e);
    end
  endtask
  // One data register access: write when w, else read
  task acc(input w, input [7:0] d);
    begin
      @(posedge CLK_I);
      DATA_WR_I <= w;
      DATA_RD_I <= !w;
      DATA_WDATA_I <= d;
      @(posedge CLK_I);
      DATA_WR_I <= 1'b0;
      DATA_RD_I <= 1'b0;
      @(posedge CLK_I);
      #1;
    end
  endtask
  task t_master;
    integer b;
    begin
      @(posedge CLK_I);
      MASTER_SELECT_I <= 1'b1;
      SW_DATA_DRIVE_ENABLE_I <= 1'b1;
      SW_CLOCK_OUT_I <= 1'b1;
      repeat (3) @(posedge CLK_I);
      #1;
      chk(pins, 4'hE);
      for (b = 0; b < 3; b = b + 1) begin
        @(posedge CLK_I);
        SW_DATA_DRIVE_ENABLE_I <= 1'b0;
        SW_CLOCK_OUT_I <= (b == 2);
        mst.sda_o <= b[0];
        repeat (8) @(posedge CLK_I);
        SW_CLOCK_OUT_I <= 1'b1;
        repeat (10) @(posedge CLK_I);
        #1;
        chk(SW_DATA_IN_O, b > 0);
      end
      @(posedge CLK_I);
      SPI_ENABLE_I <= 1'b1;
      repeat (4) @(posedge CLK_I);
      #1;
      chk({pins[3], pins[1]}, 2'b00);
      @(posedge CLK_I);
      SPI_ENABLE_I <= 1'b0;
      MASTER_SELECT_I <= 1'b0;
      mst.sda_o <= 1'b1;
      repeat (10) @(posedge CLK_I);
    end
  endtask
  task t_write;
    begin
      INT_ENABLE_I <= 1'b1;
      GLOBAL_INTERRUPT_ENABLE_I <= 1'b1;
      mst.start_c;
      mst.xfer({8'hAA, 1'b1}, rx);
      chk(rx[0], 1'b0);
      flag_wait(1'b1);
      chk({DATA_RDATA_O, SLAVE_DIRECTION_O, IRQ_O}, 10'h2A9);
      acc(1'b0, 8'h00);
      chk({BYTE_DONE_FLAG_O, IRQ_O}, 2'b00);
      mst.xfer({8'h3C, 1'b1}, rx);
      flag_wait(1'b1);
      chk(DATA_RDATA_O, 8'h3C);
      acc(1'b0, 8'h00);
      mst.stop_c;
    end
  endtask
  task t_read;
    begin
      mst.start_c;
      mst.xfer({8'hAB, 1'b1}, rx);
      flag_wait(1'b1);
      chk(SLAVE_DIRECTION_O, 1'b1);
      acc(1'b1, 8'hC5);
      mst.xfer(9'h1FF, rx);
      chk(rx[8:1], 8'hC5);
      flag_wait(1'b0);
      mst.stop_c;
      mst.start_c;
      mst.xfer({8'h20, 1'b1}, rx);
      chk(rx[0], 1'b1);
      flag_wait(1'b0);
      mst.stop_c;
    end
  endtask
  task t_halt;
    begin
      mst.start_c;
      mst.xfer({8'hAA, 1'b1}, rx);
      flag_wait(1'b1);
      acc(1'b0, 8'h00);
      acc(1'b0, 8'h00);
      chk(HALTED_O, 1'b1);
      @(posedge CLK_I);
      INTERFACE_RESET_BIT_I <= 1'b1;
      repeat (3) @(posedge CLK_I);
      #1;
      chk({BYTE_DONE_FLAG_O, HALTED_O}, 2'b00);
      @(posedge CLK_I);
      INTERFACE_RESET_BIT_I <= 1'b0;
      mst.stop_c;
      mst.start_c;
      mst.xfer({8'hAA, 1'b1}, rx);
      flag_wait(1'b1);
      acc(1'b0, 8'h00);
      mst.stop_c;
    end
  endtask
  // Hang guard
  initial begin
    #2000000;
    err_count = err_count + 1;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge CLK_I);
    RST_B_I <= 1'b1;
    repeat (8) @(posedge CLK_I);
    #1;
    chk({BYTE_DONE_FLAG_O, HALTED_O, pins[3], pins[1]}, 4'h0);
    t_master;
    t_write;
    t_read;
    t_halt;
    stop_test;
  end
endmodule

// >>> tws_top.v
// Two-wire interface: software master pins and hardware slave engine
// Notes on behaviour
// - master_select picks software master or hardware slave
// - Master drive enable puts sw_data_out on data
// - Master clock pin follows sw_clock_out always
// - Data pin latched on clock rising edge
// - Reset leaves interface in slave mode
// - Interface active only while spi_enable clear
// - Own address and data register hold traffic
// - Flag set after start, address, direction bit
// - Interrupt needs local and global enables
// - Any data register access clears the flag
// - Second access per flag halts the controller
// - Interrupt vectors to 003BH per byte
// - Address byte with direction readable after address
// - slave_direction holds master read/write bit
// - Clock held low until flag cleared
// - Flag only for bytes followed by ACK
// - Flag every acknowledged byte until stop, NACK or reset
// - Stop or NACK returns to idle
// - Interface reset bit forces slave idle
// - No status separates address from data flags
// - Line filters reject pulses under 50 ns
// - Interface reset holds slave while set
`timescale 1ns/1ps
`include "tws_map.vh"
module tws_top (
  // Clock and reset
  input wire CLK_I,
  input wire RST_B_I,
  // Control bits
  input wire MASTER_SELECT_I,
  input wire SW_DATA_OUT_I,
  input wire SW_DATA_DRIVE_ENABLE_I,
  input wire SW_CLOCK_OUT_I,
  input wire INTERFACE_RESET_BIT_I,
  input wire SPI_ENABLE_I,
  input wire INT_ENABLE_I,
  input wire GLOBAL_INTERRUPT_ENABLE_I,
  input wire [6:0] OWN_ADDRESS_I,
  // Data register access strobes
  input wire DATA_WR_I,
  input wire [7:0] DATA_WDATA_I,
  input wire DATA_RD_I,
  // Status
  output reg [7:0] DATA_RDATA_O,
  output reg SW_DATA_IN_O,
  output reg BYTE_DONE_FLAG_O,
  output reg SLAVE_DIRECTION_O,
  output reg HALTED_O,
  output wire IRQ_O,
  output wire [15:0] IRQ_VECTOR_O,
  // Two-wire pins
  input wire TWOWIRE_DATA_PIN_I,
  output reg TWOWIRE_DATA_PIN_O,
  output reg TWOWIRE_DATA_PIN_OE_O,
  input wire TWOWIRE_CLOCK_PIN_I,
  output reg TWOWIRE_CLOCK_PIN_O,
  output reg TWOWIRE_CLOCK_PIN_OE_O
);
  // Slave states
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_AACK = 3'd2;
  localparam ST_RX = 3'd3;
  localparam ST_TX = 3'd4;
  localparam ST_MACK = 3'd5;
  localparam ST_SACK = 3'd6;

  wire sda;
  wire scl;
  reg sda_d;
  reg scl_d;
  reg [2:0] state;
  reg [2:0] bitcnt;
  reg [7:0] shreg;
  reg [7:0] tx_data;
  reg stretch;
  reg acc_seen;
  reg sda_drive_low;
  reg master_d;
  // Set once all eight address bits are in; the fall right after
  // START carries no bit and must not be taken as the eighth fall
  reg addr_full;

  wire active = ~SPI_ENABLE_I;
  wire master = active & MASTER_SELECT_I;
  wire slave_on = active & ~MASTER_SELECT_I & ~INTERFACE_RESET_BIT_I;
  wire access = DATA_WR_I | DATA_RD_I;
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_det = scl & scl_d & sda_d & ~sda;
  wire stop_det = scl & scl_d & ~sda_d & sda;
  // Phases in which this slave itself may move the data line.
  // The filtered copy of our own drive lags the clock, so an edge of it
  // can land while the filtered clock is still high; START and STOP are
  // ignored here so that our own bits are never taken as bus conditions.
  wire slave_talks = (state == ST_AACK) | (state == ST_SACK) |
    (state == ST_TX) | (state == ST_MACK);

  // Filtered line copies
  tws_filter u_flt_sda (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .pin_i(TWOWIRE_DATA_PIN_I),
    .level_o(sda)
  );
  tws_filter u_flt_scl (
    .clk_i(CLK_I),
    .rst_b_i(RST_B_I),
    .pin_i(TWOWIRE_CLOCK_PIN_I),
    .level_o(scl)
  );

  // Interrupt request and fixed vector
  assign IRQ_O = BYTE_DONE_FLAG_O & INT_ENABLE_I & GLOBAL_INTERRUPT_ENABLE_I;
  assign IRQ_VECTOR_O = `TWS_VECTOR;

  // Edge history of filtered lines
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      sda_d <= 1'b1;
      scl_d <= 1'b1;
      master_d <= 1'b0;
    end else begin
      sda_d <= sda;
      scl_d <= scl;
      master_d <= master;
    end
  end

  // Software master data capture
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      SW_DATA_IN_O <= 1'b0;
    end else if (master && master_d && !SW_DATA_DRIVE_ENABLE_I && scl_rise) begin
      SW_DATA_IN_O <= sda;
    end
  end

  // Pin drivers for both modes
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      TWOWIRE_DATA_PIN_O <= 1'b0;
      TWOWIRE_DATA_PIN_OE_O <= 1'b0;
      TWOWIRE_CLOCK_PIN_O <= 1'b0;
      TWOWIRE_CLOCK_PIN_OE_O <= 1'b0;
    end else if (master) begin
      TWOWIRE_DATA_PIN_O <= SW_DATA_OUT_I;
      TWOWIRE_DATA_PIN_OE_O <= SW_DATA_DRIVE_ENABLE_I;
      TWOWIRE_CLOCK_PIN_O <= SW_CLOCK_OUT_I;
      TWOWIRE_CLOCK_PIN_OE_O <= 1'b1;
    end else begin
      TWOWIRE_DATA_PIN_O <= 1'b0;
      TWOWIRE_DATA_PIN_OE_O <= slave_on & sda_drive_low;
      TWOWIRE_CLOCK_PIN_O <= 1'b0;
      TWOWIRE_CLOCK_PIN_OE_O <= slave_on & stretch;
    end
  end

  // Slave engine
  always @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state <= ST_IDLE;
      bitcnt <= 3'd0;
      shreg <= 8'h00;
      tx_data <= `TWS_DATA_RST;
      DATA_RDATA_O <= `TWS_DATA_RST;
      BYTE_DONE_FLAG_O <= 1'b0;
      SLAVE_DIRECTION_O <= 1'b0;
      HALTED_O <= 1'b0;
      stretch <= 1'b0;
      acc_seen <= 1'b0;
      sda_drive_low <= 1'b0;
      addr_full <= 1'b0;
    end else if (!slave_on) begin
      state <= ST_IDLE;
      bitcnt <= 3'd0;
      addr_full <= 1'b0;
      BYTE_DONE_FLAG_O <= 1'b0;
      HALTED_O <= 1'b0;
      stretch <= 1'b0;
      acc_seen <= 1'b0;
      sda_drive_low <= 1'b0;
    end else begin
      // Firmware access: clears flag, second access halts
      if (access) begin
        if (BYTE_DONE_FLAG_O) begin
          BYTE_DONE_FLAG_O <= 1'b0;
          acc_seen <= 1'b1;
        end else if (acc_seen) begin
          HALTED_O <= 1'b1;
        end
        if (DATA_WR_I) begin
          tx_data <= DATA_WDATA_I;
        end
      end
      if (HALTED_O) begin
        state <= ST_IDLE;
        sda_drive_low <= 1'b0;
      end else if (stop_det && !slave_talks) begin
        state <= ST_IDLE;
        stretch <= 1'b0;
        sda_drive_low <= 1'b0;
        acc_seen <= 1'b0;
      end else if (start_det && !slave_talks) begin
        // A START outside the slave-driven phases, repeated or not, restarts address capture
        state <= ST_ADDR;
        bitcnt <= 3'd0;
        addr_full <= 1'b0;
        stretch <= 1'b0;
        sda_drive_low <= 1'b0;
        acc_seen <= 1'b0;
      end else begin
        // Release the stretch once the flag is gone
        if (stretch && !BYTE_DONE_FLAG_O && !(access && BYTE_DONE_FLAG_O)) begin
          stretch <= 1'b0;
          if (state == ST_TX) begin
            sda_drive_low <= ~tx_data[7];
            shreg <= {tx_data[6:0], 1'b0};
          end
        end
        case (state)
          // Idle: line released, wait for a START
          ST_IDLE: begin
            sda_drive_low <= 1'b0;
          end
          // Address phase: seven address bits then direction, MSB first
          ST_ADDR: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda};
              bitcnt <= bitcnt + 3'd1;
              // Eighth rise completes the address byte
              if (bitcnt == 3'd7) begin
                addr_full <= 1'b1;
              end
            end
            // Eighth fall: decide whether to acknowledge
            if (scl_fall && addr_full) begin
              addr_full <= 1'b0;
              if (shreg[7:1] == OWN_ADDRESS_I) begin
                sda_drive_low <= 1'b1;
                state <= ST_AACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          // Address acknowledge: flag and stretch at the end of ACK
          ST_AACK: begin
            if (scl_fall) begin
              DATA_RDATA_O <= shreg;
              SLAVE_DIRECTION_O <= shreg[0];
              BYTE_DONE_FLAG_O <= 1'b1;
              acc_seen <= 1'b0;
              stretch <= 1'b1;
              sda_drive_low <= 1'b0;
              bitcnt <= 3'd0;
              state <= shreg[0] ? ST_TX : ST_RX;
            end
          end
          // Receive: shift data bits in while the clock is not held
          ST_RX: begin
            if (scl_rise && !stretch) begin
              shreg <= {shreg[6:0], sda};
              bitcnt <= bitcnt + 3'd1;
            end
            if (scl_fall && !stretch && bitcnt == 3'd0) begin
              sda_drive_low <= 1'b1;
              state <= ST_SACK;
            end
          end
          // Data acknowledge: hand the byte over and hold the clock
          ST_SACK: begin
            if (scl_fall) begin
              DATA_RDATA_O <= shreg;
              BYTE_DONE_FLAG_O <= 1'b1;
              acc_seen <= 1'b0;
              stretch <= 1'b1;
              sda_drive_low <= 1'b0;
              state <= ST_RX;
            end
          end
          // Transmit: next bit goes out after each clock fall
          ST_TX: begin
            if (scl_fall && !stretch) begin
              bitcnt <= bitcnt + 3'd1;
              if (bitcnt == 3'd7) begin
                sda_drive_low <= 1'b0;
                state <= ST_MACK;
              end else begin
                sda_drive_low <= ~shreg[7];
                shreg <= {shreg[6:0], 1'b0};
              end
            end
          end
          // Master acknowledge: ACK continues, NACK ends the transfer
          ST_MACK: begin
            if (scl_rise) begin
              if (sda) begin
                state <= ST_IDLE;
              end else begin
                BYTE_DONE_FLAG_O <= 1'b1;
                acc_seen <= 1'b0;
                stretch <= 1'b1;
                bitcnt <= 3'd0;
                state <= ST_TX;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
  // flags carry no address/data distinction by design
endmodule
